// ---- lar_pkg.sv ----
// constants, register map and field layout shared by the level and relay block
package lar_pkg;

    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_MIN_CUR = 6'h04;
    localparam logic [5:0] REG_LVL_LOW = 6'h08;
    localparam logic [5:0] REG_LVL_FULL = 6'h0C;
    localparam logic [5:0] REG_AO_LO = 6'h10;
    localparam logic [5:0] REG_AO_HI = 6'h14;
    localparam logic [5:0] REG_THRESH = 6'h18;
    localparam logic [5:0] REG_DELAY = 6'h1C;
    localparam logic [5:0] REG_PLIM = 6'h20;
    localparam logic [5:0] REG_STATUS = 6'h24;
    localparam logic [5:0] REG_LEVEL = 6'h28;
    localparam logic [5:0] REG_AOUT = 6'h2C;

    // -------------------------------------------------------------
    // control and status fields
    // -------------------------------------------------------------
    localparam int CB_MEAS = 0;
    localparam int CB_HOLD = 1;
    localparam int CB_ZERO = 2;
    localparam int CB_THR_LVL = 3;
    localparam int CB_AO_LVL = 4;
    localparam int CB_POL_THR = 5;
    localparam int CB_POL_STS = 6;
    localparam int CB_POL_TOT = 7;
    localparam int CB_DUAL = 8;
    localparam int CB_CLR = 9;
    localparam int CTRL_W = 10;
    localparam logic [9:0] CTRL_RST = 10'h001;
    localparam logic [9:0] CTRL_WMASK = 10'h1FF;
    localparam int SB_FLT_A = 0;
    localparam int SB_FLT_B = 1;
    localparam int SB_FAIL = 2;
    localparam int SB_THR = 3;
    localparam int SB_STS = 4;
    localparam int SB_PATH = 5;
    localparam int SB_TOT = 6;

    // -------------------------------------------------------------
    // currents in microamps, limits and timing
    // -------------------------------------------------------------
    localparam logic [15:0] CUR_4MA = 16'h0FA0;
    localparam logic [15:0] CUR_20MA = 16'h4E20;
    localparam logic [15:0] CUR_19M8 = 16'h4D58;
    localparam logic [15:0] CUR_21MA = 16'h5208;
    localparam logic [15:0] CUR_SPAN = 16'h3E80;
    localparam logic [15:0] MIN_CUR_RST = 16'h0ED8;
    localparam logic signed [31:0] THR_MIN = 32'hFFFE7961;
    localparam logic signed [31:0] THR_MAX = 32'h000F423F;
    localparam int CNT_W = 8;
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic [7:0] PLIM_RST = 8'h03;
    localparam int CLK_HZ = 20000000;
    localparam int TOT_PULSE_MS = 100;
    localparam int TOT_W = 21;
    localparam int TOT_PULSE_DEF = TOT_PULSE_MS * (CLK_HZ / 1000);

endpackage : lar_pkg

// ---- lar_cfg_if.sv ----
// scaling configuration carried from the register file to the input scalers
`timescale 1ns/1ps
interface lar_cfg_if;
    logic [15:0] min_cur;
    logic signed [31:0] lvl_low;
    logic signed [31:0] lvl_full;
    modport src (output min_cur, output lvl_low, output lvl_full);
    modport snk (input min_cur, input lvl_low, input lvl_full);
endinterface : lar_cfg_if

// ---- lar_scale.sv ----
// fault check and linear scaling of one current-loop level input
`timescale 1ns/1ps
module lar_scale
    import lar_pkg::*;
(
    lar_cfg_if.snk cfg,
    input wire logic [15:0] cur,
    output logic below_min,
    output logic fault,
    output logic signed [31:0] lvl
);

    logic signed [63:0] lo64;
    logic signed [63:0] hi64;
    logic signed [63:0] cur64;
    logic signed [63:0] prod;

    // wide signed math so a negative span or elevation cannot wrap
    always_comb begin
        lo64 = 64'(cfg.lvl_low);
        hi64 = 64'(cfg.lvl_full);
        cur64 = $signed(64'(cur));
        below_min = cur < cfg.min_cur;
        fault = below_min || (cur > CUR_21MA); // see RQ1
        prod = (hi64 - lo64) * (cur64 - $signed(64'(CUR_4MA))); // see RQ2
        lvl = 32'(lo64 + prod / $signed(64'(CUR_SPAN))); // see RQ2
    end

endmodule : lar_scale

// ---- lar_persist.sv ----
// counter of consecutive measurement cycles for which a condition holds
`timescale 1ns/1ps
module lar_persist
    import lar_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe,
    input wire logic clr,
    input wire logic cond,
    input wire logic [CNT_W-1:0] lim,
    output logic hit
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } lar_pst_s;

    lar_pst_s st_r;
    lar_pst_s st_nxt;

    // hit on the strobe that makes the run longer than the limit
    always_comb begin
        st_nxt = st_r;
        hit = cond && (st_r.cnt >= lim); // see RQ13
        if (clr || (strobe && !cond)) begin
            st_nxt.cnt = '0;
        end else if (strobe && (st_r.cnt != '1)) begin
            st_nxt.cnt = st_r.cnt + 1'b1; // saturates, long runs stay hit
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : lar_persist

// ---- lar_top.sv ----
// level arbitration, analog output selection and alarm relays for one section
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Operation
// RQ1: level input faulty below minimum or above 21mA
// RQ2: scale current linearly between low and full levels
// RQ3: lower numbered of two inputs is primary
// RQ4: primary in normal range: use it, ignore secondary
// RQ5: primary rejected: use secondary when in range
// RQ6: both rejected: no level, section failed
// RQ7: primary high, secondary good: take greater level
// RQ8: primary high, secondary rejected: use primary
// RQ9: analog output linear between two range ends
// RQ10: on fault drive 4mA, hold, or zero
// RQ11: clamp output to 4mA under, 20mA over
// RQ12: outside measuring mode the output freezes
// RQ13: threshold relay trips after delay plus one cycles
// RQ14: tripped relay releases after delay plus one below
// RQ15: failed section forces threshold relay normal at once
// RQ16: polarity bit picks energized or de-energized normal
// RQ17: signed trip value limited to -99999..999999
// RQ18: status relay acts after persistent fault, clears immediately
// RQ19: path fault after limit, relay delay on top
// RQ20: totalizer pulses 100ms per whole volume unit
// RQ21: single totalizer relay serves this section
// RQ22: catch-up pulses once per cycle after outage
// RQ23: all updates on strobe; clear restores normal
// -----------------------------------------------------------------
module lar_top
    import lar_pkg::*;
#(
    parameter int TOT_PULSE_CYC = TOT_PULSE_DEF
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic meas_strobe,
    input wire logic [15:0] cur_a,
    input wire logic [15:0] cur_b,
    input wire logic signed [31:0] flow_val,
    input wire logic flow_fault,
    input wire logic path_fail,
    input wire logic [31:0] vol_units,
    output logic signed [31:0] sect_level,
    output logic sect_fail,
    output logic [15:0] aout_ua,
    output logic relay_thr,
    output logic relay_sts,
    output logic relay_tot
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [15:0] min_cur;
        logic signed [31:0] lvl_low;
        logic signed [31:0] lvl_full;
        logic signed [31:0] ao_lo;
        logic signed [31:0] ao_hi;
        logic signed [31:0] thresh;
        logic [CNT_W-1:0] delay;
        logic [CNT_W-1:0] plim;
        logic ack;
        logic [31:0] rdata;
        logic signed [31:0] level;
        logic fail;
        logic [15:0] aout;
        logic thr_trip;
        logic sts_act;
        logic path_flt;
        logic init;
        logic clr;
        logic [31:0] issued;
        logic [TOT_W-1:0] tot_cnt;
    } lar_st_s;

    localparam lar_st_s ST_RST = '{ctrl: CTRL_RST, min_cur: MIN_CUR_RST,
        delay: DELAY_RST, plim: PLIM_RST, default: '0};

    lar_st_s st_r;
    lar_st_s st_nxt;
    logic rst_s1_r;
    logic rst_n;
    logic flt_a;
    logic flt_b;
    logic low_a;
    logic low_b;
    logic signed [31:0] lvl_a;
    logic signed [31:0] lvl_b;
    logic signed [31:0] lvl_max;
    logic signed [31:0] lvl_now;
    logic fail_now;
    logic signed [31:0] ao_var;
    logic signed [31:0] thr_var;
    logic ao_bad;
    logic thr_ge;
    logic thr_hit;
    logic thr_clr;
    logic sts_hit;
    logic path_hit;
    logic tot_pend;
    logic tot_on;
    logic wr_acc;
    logic [31:0] wd;
    logic [31:0] rd_mux;
    logic [31:0] sts_word;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic signed [31:0] thr_clamp(input logic signed [31:0] v);
        if (v < THR_MIN) begin
            return THR_MIN; // see RQ17
        end else if (v > THR_MAX) begin
            return THR_MAX; // see RQ17
        end
        return v;
    endfunction : thr_clamp

    // caller guarantees lo <= v <= hi, so the quotient is never negative
    function automatic logic [15:0] ao_scale(input logic signed [31:0] v,
                                             input logic signed [31:0] lo,
                                             input logic signed [31:0] hi);
        logic signed [63:0] num;
        logic signed [63:0] den;
        num = (64'(v) - 64'(lo)) * $signed(64'(CUR_SPAN));
        den = 64'(hi) - 64'(lo);
        if (den <= 0) begin
            return CUR_4MA;
        end
        return 16'(64'(CUR_4MA) + num / den); // see RQ9
    endfunction : ao_scale

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    // assertion is immediate, release waits two edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // -------------------------------------------------------------
    // input scaling and arbitration
    // -------------------------------------------------------------
    lar_cfg_if cfg_if ();

    assign cfg_if.min_cur = st_r.min_cur;
    assign cfg_if.lvl_low = st_r.lvl_low;
    assign cfg_if.lvl_full = st_r.lvl_full;

    // input a is the lower numbered, hence primary
    lar_scale u_scale_a (.cfg(cfg_if), .cur(cur_a), .below_min(low_a), .fault(flt_a),
        .lvl(lvl_a)); // see RQ3
    lar_scale u_scale_b (.cfg(cfg_if), .cur(cur_b), .below_min(low_b), .fault(flt_b),
        .lvl(lvl_b));

    assign lvl_max = (lvl_b > lvl_a) ? lvl_b : lvl_a;

    // dual mode rejects primary only under range, secondary also above 20mA while primary is under range; primary over 21mA still arbitrates high
    always_comb begin
        fail_now = 1'b0;
        lvl_now = lvl_a;
        if (!st_r.ctrl[CB_DUAL]) begin
            fail_now = flt_a; // see RQ1
        end else if (!low_a && (cur_a <= CUR_19M8)) begin
            lvl_now = lvl_a; // see RQ4
        end else if (low_a) begin
            if (low_b || (cur_b > CUR_20MA)) begin
                fail_now = 1'b1; // see RQ6
            end else begin
                lvl_now = lvl_b; // see RQ5
            end
        end else if (!low_b) begin
            lvl_now = lvl_max; // see RQ7
        end else begin
            lvl_now = lvl_a; // see RQ8
        end
    end

    // -------------------------------------------------------------
    // relay timing
    // -------------------------------------------------------------
    assign ao_var = st_r.ctrl[CB_AO_LVL] ? lvl_now : flow_val;
    assign ao_bad = st_r.ctrl[CB_AO_LVL] ? fail_now : flow_fault;
    assign thr_var = st_r.ctrl[CB_THR_LVL] ? lvl_now : flow_val;
    assign thr_ge = thr_var >= st_r.thresh; // see RQ17
    assign thr_clr = st_r.clr || (meas_strobe && (fail_now || thr_hit));
    assign tot_pend = vol_units > st_r.issued;
    assign tot_on = st_r.tot_cnt != '0;

    // one counter serves both directions; it restarts on each toggle
    lar_persist u_thr (.clk(core_clk), .rst_n(rst_n), .strobe(meas_strobe), .clr(thr_clr),
        .cond(st_r.thr_trip ? !thr_ge : thr_ge), .lim(st_r.delay), .hit(thr_hit)); // see RQ14

    lar_persist u_path (.clk(core_clk), .rst_n(rst_n), .strobe(meas_strobe), .clr(st_r.clr),
        .cond(path_fail), .lim(st_r.plim), .hit(path_hit)); // see RQ19

    // status delay stacks on the path limit above
    lar_persist u_sts (.clk(core_clk), .rst_n(rst_n), .strobe(meas_strobe), .clr(st_r.clr),
        .cond(fail_now || path_hit), .lim(st_r.delay), .hit(sts_hit)); // see RQ19

    // -------------------------------------------------------------
    // register read mux
    // -------------------------------------------------------------
    always_comb begin
        sts_word = '0;
        sts_word[SB_FLT_A] = flt_a;
        sts_word[SB_FLT_B] = flt_b;
        sts_word[SB_FAIL] = st_r.fail;
        sts_word[SB_THR] = st_r.thr_trip;
        sts_word[SB_STS] = st_r.sts_act;
        sts_word[SB_PATH] = st_r.path_flt;
        sts_word[SB_TOT] = tot_on;
        if (avs_address == REG_CTRL) begin
            rd_mux = 32'(st_r.ctrl);
        end else if (avs_address == REG_MIN_CUR) begin
            rd_mux = 32'(st_r.min_cur);
        end else if (avs_address == REG_LVL_LOW) begin
            rd_mux = st_r.lvl_low;
        end else if (avs_address == REG_LVL_FULL) begin
            rd_mux = st_r.lvl_full;
        end else if (avs_address == REG_AO_LO) begin
            rd_mux = st_r.ao_lo;
        end else if (avs_address == REG_AO_HI) begin
            rd_mux = st_r.ao_hi;
        end else if (avs_address == REG_THRESH) begin
            rd_mux = st_r.thresh;
        end else if (avs_address == REG_DELAY) begin
            rd_mux = 32'(st_r.delay);
        end else if (avs_address == REG_PLIM) begin
            rd_mux = 32'(st_r.plim);
        end else if (avs_address == REG_STATUS) begin
            rd_mux = sts_word;
        end else if (avs_address == REG_LEVEL) begin
            rd_mux = st_r.level;
        end else if (avs_address == REG_AOUT) begin
            rd_mux = 32'(st_r.aout);
        end else begin
            rd_mux = '0;
        end
    end

    // -------------------------------------------------------------
    // next state: bus, evaluation, totalizer
    // -------------------------------------------------------------
    assign wr_acc = avs_write && st_r.ack;

    always_comb begin
        st_nxt = st_r;
        st_nxt.clr = 1'b0;
        wd = '0;
        // one wait cycle: latch read data first, acknowledge next
        st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
        if (avs_read && !st_r.ack) begin
            st_nxt.rdata = rd_mux;
        end
        if (wr_acc) begin
            if (avs_address == REG_CTRL) begin
                wd = be_merge(32'(st_r.ctrl), avs_writedata, avs_byteenable);
                st_nxt.ctrl = CTRL_W'(wd) & CTRL_WMASK;
                st_nxt.clr = wd[CB_CLR];
            end else if (avs_address == REG_MIN_CUR) begin
                st_nxt.min_cur = 16'(be_merge(32'(st_r.min_cur), avs_writedata, avs_byteenable));
            end else if (avs_address == REG_LVL_LOW) begin
                st_nxt.lvl_low = be_merge(st_r.lvl_low, avs_writedata, avs_byteenable);
            end else if (avs_address == REG_LVL_FULL) begin
                st_nxt.lvl_full = be_merge(st_r.lvl_full, avs_writedata, avs_byteenable);
            end else if (avs_address == REG_AO_LO) begin
                st_nxt.ao_lo = be_merge(st_r.ao_lo, avs_writedata, avs_byteenable);
            end else if (avs_address == REG_AO_HI) begin
                st_nxt.ao_hi = be_merge(st_r.ao_hi, avs_writedata, avs_byteenable);
            end else if (avs_address == REG_THRESH) begin
                st_nxt.thresh = thr_clamp(be_merge(st_r.thresh, avs_writedata, avs_byteenable));
            end else if (avs_address == REG_DELAY) begin
                st_nxt.delay = CNT_W'(be_merge(32'(st_r.delay), avs_writedata, avs_byteenable));
            end else if (avs_address == REG_PLIM) begin
                st_nxt.plim = CNT_W'(be_merge(32'(st_r.plim), avs_writedata, avs_byteenable));
            end
        end
        if (tot_on) begin
            st_nxt.tot_cnt = st_r.tot_cnt - 1'b1;
        end
        if (st_r.clr) begin
            // soft clear puts every relay back to normal
            st_nxt.thr_trip = 1'b0; // see RQ23
            st_nxt.sts_act = 1'b0;
            st_nxt.path_flt = 1'b0;
            st_nxt.tot_cnt = '0;
        end else if (meas_strobe) begin
            st_nxt.fail = fail_now; // see RQ23
            st_nxt.level = fail_now ? '0 : lvl_now; // see RQ6
            if (st_r.ctrl[CB_MEAS]) begin // see RQ12
                if (ao_bad) begin
                    if (st_r.ctrl[CB_ZERO]) begin
                        st_nxt.aout = '0; // see RQ10
                    end else if (!st_r.ctrl[CB_HOLD]) begin
                        st_nxt.aout = CUR_4MA; // see RQ10
                    end
                end else if (ao_var < st_r.ao_lo) begin
                    st_nxt.aout = CUR_4MA; // see RQ11
                end else if (ao_var > st_r.ao_hi) begin
                    st_nxt.aout = CUR_20MA; // see RQ11
                end else begin
                    st_nxt.aout = ao_scale(ao_var, st_r.ao_lo, st_r.ao_hi); // see RQ9
                end
            end
            if (fail_now) begin
                st_nxt.thr_trip = 1'b0; // see RQ15
            end else if (thr_hit) begin
                st_nxt.thr_trip = !st_r.thr_trip; // see RQ13
            end
            st_nxt.path_flt = path_hit;
            st_nxt.sts_act = sts_hit; // see RQ18
            // the only totalizer of this section; catches up one unit per cycle
            if (!st_r.init) begin
                st_nxt.init = 1'b1;
                st_nxt.issued = vol_units;
            end else if (st_r.ctrl[CB_MEAS] && tot_pend && !tot_on) begin // see RQ21
                st_nxt.tot_cnt = TOT_W'(TOT_PULSE_CYC); // see RQ20
                st_nxt.issued = st_r.issued + 32'h1; // see RQ22
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
    assign avs_readdata = st_r.rdata;
    assign sect_level = st_r.level;
    assign sect_fail = st_r.fail;
    assign aout_ua = st_r.aout;
    assign relay_thr = st_r.thr_trip ^ st_r.ctrl[CB_POL_THR]; // see RQ16
    assign relay_sts = st_r.sts_act ^ st_r.ctrl[CB_POL_STS]; // see RQ16
    assign relay_tot = tot_on ^ st_r.ctrl[CB_POL_TOT]; // see RQ16

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_eval;
        meas_strobe && !st_r.clr;
    endsequence

    sequence s_tot_start;
        s_eval ##0 (st_r.init && st_r.ctrl[CB_MEAS] && tot_pend && !tot_on);
    endsequence

    a_single_fault: assert property ( // see RQ1
        s_eval ##0 (!st_r.ctrl[CB_DUAL] && (cur_a > CUR_21MA)) |=> sect_fail)
        else $error("over-range single input did not fail the section");
    a_prim_used: assert property ( // see RQ4
        s_eval ##0 (st_r.ctrl[CB_DUAL] && !low_a && (cur_a <= CUR_19M8))
        |=> (sect_level == $past(lvl_a)) && !sect_fail)
        else $error("primary in range was not used");
    a_both_rejected: assert property ( // see RQ6
        s_eval ##0 (st_r.ctrl[CB_DUAL] && low_a && low_b) |=> sect_fail && (sect_level == 0))
        else $error("both inputs low but section not failed");
    a_greater_pick: assert property ( // see RQ7
        s_eval ##0 (st_r.ctrl[CB_DUAL] && !low_a && (cur_a > CUR_19M8) && !low_b)
        |=> sect_level == $past(lvl_max))
        else $error("high primary did not take the greater level");
    a_clamp_under: assert property ( // see RQ11
        s_eval ##0 (st_r.ctrl[CB_MEAS] && !ao_bad && (ao_var < st_r.ao_lo))
        |=> aout_ua == CUR_4MA)
        else $error("under-range output not at 4mA");
    a_freeze_idle: assert property ( // see RQ12
        !st_r.ctrl[CB_MEAS] |=> $stable(aout_ua))
        else $error("analog output moved outside measuring mode");
    a_fail_normal: assert property ( // see RQ15
        s_eval ##0 fail_now |=> (relay_thr == st_r.ctrl[CB_POL_THR]))
        else $error("threshold relay not normal on failed section");
    a_sts_revert: assert property ( // see RQ18
        s_eval ##0 (!fail_now && !path_hit) |=> !st_r.sts_act)
        else $error("status relay did not revert when fault cleared");
    a_tot_pulse: assert property ( // see RQ20
        s_tot_start |=> (st_r.issued == $past(st_r.issued) + 32'h1) ##0 tot_on[*8])
        else $error("totalizer pulse too short or count not advanced");

endmodule : lar_top

// ---- lar_sensor.sv ----
// loop-current sources standing in for the two level sensors
`timescale 1ns/1ps
module lar_sensor (
    input wire logic core_clk,
    input wire logic [15:0] want_a,
    input wire logic [15:0] want_b,
    output logic [15:0] cur_a,
    output logic [15:0] cur_b
);
    // a loop settles one cycle after a new depth is asked for
    always @(posedge core_clk) begin
        cur_a <= want_a;
        cur_b <= want_b;
    end
endmodule : lar_sensor

// ---- lar_tb.sv ----
// self-checking bench for level arbitration, analog output and threshold relay
`timescale 1ns/1ps
module testbench;
    import lar_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic meas_strobe = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, sect_fail, relay_thr, relay_sts, relay_tot, frz = 1'b0;
    logic [31:0] vol = 32'h0, ao_exp = 32'h0;
    logic [15:0] want_a = 16'h0FA0, want_b = 16'h0FA0, cur_a, cur_b, aout_ua;
    logic signed [31:0] sect_level;
    logic [15:0] lf = 16'h489F;
    int bad_count = 0, compares = 0;
    // -------------------------------------------------------------
    // clock, sensors and block
    // -------------------------------------------------------------
    always #25 core_clk = ~core_clk;
    lar_sensor SENS (.core_clk(core_clk), .want_a(want_a), .want_b(want_b),
        .cur_a(cur_a), .cur_b(cur_b));
    lar_top #(.TOT_PULSE_CYC(20)) DUT (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .meas_strobe(meas_strobe), .cur_a(cur_a),
        .cur_b(cur_b), .flow_val(32'h0), .flow_fault(1'b0), .path_fail(1'b0),
        .vol_units(vol), .sect_level(sect_level), .sect_fail(sect_fail),
        .aout_ua(aout_ua), .relay_thr(relay_thr), .relay_sts(relay_sts),
        .relay_tot(relay_tot));
    task automatic give_verdict();
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk iff !avs_waitrequest);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    // level is current minus 4 mA with the scaling set below; pick < min means failed
    function automatic logic [31:0] exp_lvl(input logic dual, input int a, input int b,
        output logic f);
        int pick;
        pick = a;
        if (dual && a < 3800)
            pick = (b >= 3800 && b <= 20000) ? b : -1;
        else if (dual && a > 19800 && b >= 3800 && b > a)
            pick = b;
        f = (!dual && a > 21000) || pick < 3800;
        return f ? 32'h0 : 32'(pick - 4000);
    endfunction : exp_lvl
    task automatic meas(input logic dual, input int a, input int b);
        logic f;
        logic signed [31:0] lv;
        lv = exp_lvl(dual, a, b, f);
        // outside measuring mode the last expectation stands
        if (!frz)
            ao_exp = (f || lv < 0) ? 32'd4000 : (lv > 16000 ? 32'd20000 : lv + 4000);
        @(posedge core_clk);
        want_a <= 16'(a);
        want_b <= 16'(b);
        @(posedge core_clk);
        meas_strobe <= 1'b1;
        @(posedge core_clk);
        meas_strobe <= 1'b0;
        @(negedge core_clk);
        check("sect_fail", {31'h0, f}, {31'h0, sect_fail});
        check("sect_level", lv, sect_level);
        check("aout_ua", ao_exp, {16'h0, aout_ua});
    endtask : meas
    initial begin
        int a;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        bus(1'b0, REG_MIN_CUR, 32'h0);
        check("min_cur", 32'h0ED8, avs_readdata);
        bus(1'b0, 6'h3C, 32'h0);
        check("unmapped", 32'h0, avs_readdata);
        bus(1'b1, REG_LVL_FULL, 32'h3E80);
        bus(1'b1, REG_AO_HI, 32'h3E80);
        bus(1'b1, REG_CTRL, 32'h019);
        meas(1'b0, 21001, 0);
        meas(1'b0, 3799, 0);
        meas(1'b0, 3900, 0);
        // random currents, single input first, then two inputs
        for (int i = 0; i < 40; i++) begin
            if (i == 20)
                bus(1'b1, REG_CTRL, 32'h119);
            lf = step(lf);
            a = lf % 22000;
            lf = step(lf);
            meas(i >= 20, a, lf % 22000);
        end
        meas(1'b1, 3000, 12000);
        meas(1'b1, 3000, 3000);
        check("relay_sts", 32'h1, {31'h0, relay_sts});
        meas(1'b1, 20500, 19000);
        meas(1'b1, 19900, 20600);
        meas(1'b1, 20000, 100);
        bus(1'b1, REG_THRESH, 32'd5000);
        bus(1'b1, REG_DELAY, 32'd2);
        vol <= 32'h1;
        meas(1'b1, 100, 100);
        check("relay_tot", 32'h1, {31'h0, relay_tot});
        for (int i = 0; i < 3; i++) begin
            meas(1'b1, 15000, 0);
            check("relay_thr", {31'h0, i == 2}, {31'h0, relay_thr});
        end
        meas(1'b1, 100, 100);
        check("relay_thr", 32'h0, {31'h0, relay_thr});
        // measuring off: level still tracks, analog output must not move
        bus(1'b1, REG_CTRL, 32'h118);
        frz = 1'b1;
        meas(1'b1, 15000, 0);
        give_verdict();
    end
    // hang guard, far beyond the few hundred cycles of the run
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
endmodule : testbench
